/* File: hdl/sba_arbiter.sv */
// Secondary bus arbiter with bus parking for both sides of the bridge.
// Assumes all pins sampled on mclk; priority bits are written by a strobe from the core.
`timescale 1ns/10ps

module sba_arbiter
  import sba_pkg::*;
#(
  parameter int NUM_EXT = SBA_NUM_EXT
) (
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic              central_function_enable_n,
  input  wire logic [8:0]        sec_request_n,
  input  wire sba_bus_type       sec_bus,
  input  wire logic              bridge_sec_request,
  input  wire logic              prio_write,
  input  wire logic [9:0]        prio_value,
  input  wire logic              pri_grant_n,
  input  wire logic              pri_request_n,
  input  wire sba_bus_type       pri_bus,
  input  wire logic              pri_pending,
  output logic      [8:0]        sec_grant_n,
  output logic                   bridge_sec_grant,
  output logic                   sec_start_ok,
  output logic                   pri_start_ok,
  output sba_park_type           sec_park,
  output sba_park_type           pri_park
);

  if (NUM_EXT != SBA_NUM_EXT) begin : g_bad_num
    $error("sba_arbiter: NUM_EXT must equal the package master count");
  end

  // ****************************************************************
  // Declarations
  // ****************************************************************
  sba_state_type s;
  sba_state_type next_s;
  logic [9:0]    reqv;
  logic [9:0]    avail;
  logic [3:0]    win;
  logic          win_valid;
  logic          sec_idle;
  logic          pri_idle;
  logic          frame_start;
  logic          timeout;
  logic          ext_gnt;
  logic          sec_park_cond;
  logic          pri_park_cond;
  logic [8:0]    next_grant_n;
  logic          next_bridge_grant;
  logic          next_sec_start;
  logic          next_pri_start;
  logic [9:0]    gv;

  // ****************************************************************
  // Request vector and priority search
  // ****************************************************************
  // Index 0 is the bridge, index i is external master i-1.
  assign reqv        = {~sec_request_n, bridge_sec_request}; // R1
  assign avail       = reqv & ~s.blocked; // R11
  assign sec_idle    = sec_bus.cycle_frame_n & sec_bus.initiator_ready_n;
  assign pri_idle    = pri_bus.cycle_frame_n & pri_bus.initiator_ready_n;
  assign frame_start = ~sec_bus.cycle_frame_n & s.frame_d; // R7
  assign ext_gnt     = ~sec_request_n[0]; // R14

  // The grant counter ignores a parked master that is not asking, so
  // parking survives long idle stretches.
  assign timeout = (s.fsm == SBA_ST_GRANT) && sec_idle && reqv[s.owner]
                   && (s.tcount == SBA_TIMEOUT_LAST); // R10

  sba_rotate #(
    .N         (SBA_NUM_MASTERS)
  ) u_rotate (
    .avail     (avail),
    .hi        (s.prio),
    .hi_last   (s.hi_last),
    .lo_last   (s.lo_last),
    .win       (win),
    .win_valid (win_valid)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_s         = s;
    next_s.frame_d = sec_bus.cycle_frame_n;
    next_s.req_out = bridge_sec_request;

    // The strap is caught once, on the first clock after reset.
    if (!s.strap_done) begin
      next_s.strap_done = 1'b1;
      next_s.ext_mode   = central_function_enable_n; // R14
    end

    if (prio_write) begin
      next_s.prio = prio_value; // R4
    end

    for (int i = 0; i < SBA_NUM_MASTERS; i++) begin
      if (!reqv[i]) begin
        next_s.blocked[i] = 1'b0; // R11
      end
    end

    if (frame_start && s.fsm == SBA_ST_GRANT) begin
      if (s.prio[s.owner]) begin
        next_s.hi_last = s.owner; // R9
      end else begin
        next_s.hi_last = SBA_LOW_SLOT; // R2
        next_s.lo_last = s.owner; // R3
      end
    end

    if (s.fsm == SBA_ST_GRANT && sec_idle && reqv[s.owner]) begin
      next_s.tcount = s.tcount + SBA_COUNT_STEP;
    end else begin
      next_s.tcount = '0;
    end

    case (s.fsm)
      SBA_ST_GRANT: begin
        if (s.strap_done && s.ext_mode) begin
          next_s.fsm = SBA_ST_EXT;
        end else if (timeout) begin
          next_s.blocked[s.owner] = 1'b1; // R11
          next_s.fsm              = SBA_ST_GAP; // R10
          next_s.tcount           = '0;
        end else if (win_valid && win != s.owner) begin
          next_s.tcount = '0;
          if (sec_idle) begin
            next_s.fsm = SBA_ST_GAP; // R12
          end else begin
            next_s.owner = win; // R13
          end
        end
      end
      SBA_ST_GAP: begin
        if (win_valid) begin
          next_s.owner = win; // R8
          next_s.fsm   = SBA_ST_GRANT;
        end
      end
      SBA_ST_EXT: begin
        next_s.fsm = SBA_ST_EXT;
      end
      default: begin
        next_s.fsm = SBA_ST_GAP;
      end
    endcase
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_comb begin
    next_grant_n      = '1;
    next_bridge_grant = 1'b0;
    next_sec_start    = 1'b0;
    sec_park_cond     = 1'b0;
    if (next_s.fsm == SBA_ST_EXT) begin
      next_grant_n[0]   = ~bridge_sec_request; // R17
      next_bridge_grant = ext_gnt && s.req_out;
      next_sec_start    = ext_gnt && s.req_out && sec_idle; // R15
      sec_park_cond     = ext_gnt && !s.req_out && !bridge_sec_request
                          && sec_idle; // R16
    end else begin
      for (int i = 1; i < SBA_NUM_MASTERS; i++) begin
        next_grant_n[i-1] = !(next_s.fsm == SBA_ST_GRANT && next_s.owner == i[3:0]); // R21
      end
      next_bridge_grant = next_s.fsm == SBA_ST_GRANT && next_s.owner == SBA_BRIDGE_IDX;
      next_sec_start    = s.fsm == SBA_ST_GRANT && s.owner == SBA_BRIDGE_IDX
                          && bridge_sec_request && sec_idle;
      sec_park_cond     = s.fsm == SBA_ST_GRANT && s.owner == SBA_BRIDGE_IDX
                          && !bridge_sec_request && sec_idle; // R22
    end
    pri_park_cond  = !pri_grant_n && pri_request_n && pri_idle; // R19
    next_pri_start = pri_park.adcbe_oe && pri_pending && !pri_grant_n; // R20
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s.strap_done     <= 1'b0;
      s.ext_mode       <= 1'b0;
      s.prio           <= SBA_RST_PRIORITY; // R6
      s.hi_last        <= SBA_RST_HI_LAST;
      s.lo_last        <= SBA_RST_LO_LAST;
      s.owner          <= SBA_BRIDGE_IDX; // R22
      s.fsm            <= SBA_ST_GRANT;
      s.blocked        <= '0;
      s.tcount         <= '0;
      s.frame_d        <= 1'b1;
      s.req_out        <= 1'b0;
      sec_grant_n      <= '1;
      bridge_sec_grant <= 1'b1;
      sec_start_ok     <= 1'b0;
      pri_start_ok     <= 1'b0;
    end else begin
      s                <= next_s;
      sec_grant_n      <= next_grant_n;
      bridge_sec_grant <= next_bridge_grant;
      sec_start_ok     <= next_sec_start;
      pri_start_ok     <= next_pri_start;
    end
  end

  sba_park u_sec_park (
    .mclk      (mclk),
    .rst       (rst),
    .park_cond (sec_park_cond),
    .park      (sec_park)
  );

  sba_park u_pri_park (
    .mclk      (mclk),
    .rst       (rst),
    .park_cond (pri_park_cond),
    .park      (pri_park)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  assign gv = {~sec_grant_n, bridge_sec_grant};

  // In external mode bit 0 carries the request out, so it may stand beside the bridge grant.
  one_grant_a : assert property (!s.ext_mode |-> $onehot0(gv)) // R1
    else $error("more than one secondary grant active");

  idle_gap_a : assert property (!s.ext_mode && $past(sec_idle) && $past(|gv) && |gv // R12
    |-> gv == $past(gv))
    else $error("grant moved on an idle bus without a gap");

  grant_timeout_a : assert property (timeout |=> gv == 10'h000) // R10
    else $error("grant not removed after timeout");

  blocked_grant_a : assert property ((s.blocked & gv) == 10'h000) // R11
    else $error("timed-out master granted again");

  park_hold_a : assert property (s.fsm == SBA_ST_GRANT && avail == 10'h000 // R21
    && !s.ext_mode |=> gv == $past(gv))
    else $error("parked grant moved without a request");

  reset_park_a : assert property ($past(rst) |-> bridge_sec_grant) // R22
    else $error("bus not parked at bridge after reset");

  ext_unused_a : assert property (s.ext_mode |=> sec_grant_n[8:1] == 8'hff) // R17
    else $error("unused grants not high in external mode");

  ext_start_a : assert property (s.fsm == SBA_ST_EXT && ext_gnt && s.req_out // R15
    && sec_idle |=> sec_start_ok)
    else $error("no start one cycle after external grant");

  pri_start_a : assert property (pri_start_ok |-> $past(!pri_grant_n) // R20
    && $past(pri_park.adcbe_oe))
    else $error("primary start without parked grant");

endmodule

/* File: hdl/sba_park.sv */
// Parking driver enables for one bus: address/data and command first, parity a clock later.
// The caller supplies the full parking condition; enables fall the clock after it ends.
`timescale 1ns/10ps

module sba_park
  import sba_pkg::*;
(
  input  wire logic         mclk,
  input  wire logic         rst,
  input  wire logic         park_cond,
  output sba_park_type      park
);

  sba_park_type s;
  sba_park_type next_s;

  always_comb begin
    next_s.adcbe_oe = park_cond;
    next_s.par_oe   = park_cond & s.adcbe_oe; // R18
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign park = s;

  sequence lines_first_s;
    !s.adcbe_oe ##1 s.adcbe_oe && !s.par_oe;
  endsequence

  park_order_a : assert property (@(posedge mclk) disable iff (rst) // R18
    lines_first_s ##0 park_cond |=> s.par_oe)
    else $error("parity drive did not follow address drive by one clock");

  park_release_a : assert property (@(posedge mclk) disable iff (rst) // R19
    !park_cond |=> !s.adcbe_oe && !s.par_oe)
    else $error("parking drivers not released after condition ended");

endmodule

/* File: hdl/sba_pkg.sv */
// Constants and carrier types of the secondary bus arbiter and bus parking logic.
// Assumes one clock, mclk, and a synchronous active-high reset; bus pins are synchronous.
//
// Operation
// R1: Strap low enables the arbiter: nine request inputs, nine grants, bridge request internal.
// R2: The whole low group is one entry in the high-priority rotation.
// R3: Priority rotates evenly inside the low group, one member per group turn.
// R4: One priority bit per master; 1 is high group, 0 is low group.
// R5: All masters in one group gives a plain rotating priority.
// R6: After reset externals are low group and the bridge is high group.
// R7: Priorities re-evaluate at frame start; highest asserted request is granted meanwhile.
// R8: A higher-priority request replaces the current grant on the next clock.
// R9: The previous initiator becomes lowest in its group; its successor gets top priority.
// R10: Grant is removed after 16 idle granted cycles without frame.
// R11: A timed-out master gets no grant until it drops its request once.
// R12: On an idle bus a new grant comes one clock after the old drops.
// R13: On a busy bus the grant may move within one clock.
// R14: Strap high: external arbiter; grant 0 is request out, request 0 grant in.
// R15: External grant with own request asserted starts a transaction one cycle later.
// R16: External mode parks only with grant in, no own request, idle bus.
// R17: External mode drives grants 8 to 1 high; board pulls requests 8 to 1 high.
// R18: Parking drives address/data and command lines first, parity one cycle later.
// R19: Primary parks with grant, no request, idle bus; releases after grant drops.
// R20: Parked on primary with work pending, frame may start if grant remains.
// R21: Internal arbiter keeps the grant at the last master until a new request.
// R22: After reset the secondary bus is parked at the bridge.

package sba_pkg;

  // ****************************************************************
  // Sizes and codes
  // ****************************************************************
  localparam int         SBA_NUM_EXT      = 9;
  localparam int         SBA_NUM_MASTERS  = SBA_NUM_EXT + 1;
  localparam int         SBA_IDX_W        = 4;
  localparam logic [3:0] SBA_BRIDGE_IDX   = 4'h0;
  localparam logic [3:0] SBA_LOW_SLOT     = 4'ha;
  localparam logic [3:0] SBA_RST_HI_LAST  = 4'ha;
  localparam logic [3:0] SBA_RST_LO_LAST  = 4'h9;
  localparam logic [9:0] SBA_RST_PRIORITY = 10'h001;
  localparam logic [4:0] SBA_TIMEOUT_LAST = 5'h0f;
  localparam logic [4:0] SBA_COUNT_STEP   = 5'h01;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    SBA_ST_GRANT = 3'b001,
    SBA_ST_GAP   = 3'b010,
    SBA_ST_EXT   = 3'b100
  } sba_fsm_type;

  typedef struct packed {
    logic cycle_frame_n;
    logic initiator_ready_n;
  } sba_bus_type;

  typedef struct packed {
    logic adcbe_oe;
    logic par_oe;
  } sba_park_type;

  typedef struct packed {
    logic        strap_done;
    logic        ext_mode;
    logic [9:0]  prio;
    logic [3:0]  hi_last;
    logic [3:0]  lo_last;
    logic [3:0]  owner;
    sba_fsm_type fsm;
    logic [9:0]  blocked;
    logic [4:0]  tcount;
    logic        frame_d;
    logic        req_out;
  } sba_state_type;

endpackage

/* File: hdl/sba_rotate.sv */
// Two-level rotating priority search over the masters of the secondary bus.
// Purely combinational; pointers come from the arbiter state, the request vector from the request pins masked by the blocked bits.
`timescale 1ns/10ps

module sba_rotate
  import sba_pkg::*;
#(
  parameter int N = SBA_NUM_MASTERS
) (
  input  wire logic [N-1:0]   avail,
  input  wire logic [N-1:0]   hi,
  input  wire logic [3:0]     hi_last,
  input  wire logic [3:0]     lo_last,
  output logic      [3:0]     win,
  output logic                win_valid
);

  if (N < 2 || N > 15) begin : g_bad_n
    $error("sba_rotate: N must lie between 2 and 15");
  end

  logic [N-1:0] lo_req;
  logic         slot_found;
  logic         lo_found;
  int           slot;
  int           idx;

  // ****************************************************************
  // Search
  // ****************************************************************
  // The low group takes slot N of the high rotation; it competes only
  // when one of its members asks, so an empty group never blocks.
  always_comb begin
    lo_req     = avail & ~hi; // R2
    slot_found = 1'b0;
    lo_found   = 1'b0;
    win        = 4'h0;
    win_valid  = 1'b0;
    slot       = 0;
    idx        = 0;
    for (int k = 1; k <= N + 1; k++) begin
      idx = (int'(hi_last) + k) % (N + 1);
      if (!slot_found) begin
        if (idx == N && |lo_req) begin
          slot_found = 1'b1; // R5
          slot       = idx;
        end else if (idx < N && hi[idx] && avail[idx]) begin
          slot_found = 1'b1;
          slot       = idx;
        end
      end
    end
    if (slot_found && slot == N) begin
      for (int k = 1; k <= N; k++) begin
        idx = (int'(lo_last) + k) % N;
        if (!lo_found && lo_req[idx]) begin
          lo_found = 1'b1; // R3
          win      = idx[3:0];
        end
      end
      win_valid = lo_found;
    end else if (slot_found) begin
      win       = slot[3:0];
      win_valid = 1'b1;
    end
  end

endmodule

/* File: verif/sba_arbiter_test.sv */
// Self-checking bench for the secondary arbiter and both parking paths.
// Assumes the master model sba_masters; inputs change on falling edges.
`timescale 1ns/10ps

module sba_arbiter_test
  import sba_pkg::*;
;
  logic         mclk, rst, strap, prio_write, slow, ext_gnt;
  logic         pri_grant_n, pri_request_n, pri_pending, start;
  logic         bridge_sec_grant, sec_start_ok, pri_start_ok, ip, ipp;
  logic [9:0]   want, stall, prio_value, pg;
  logic [8:0]   sec_request_n, sec_grant_n;
  logic [3:0]   init;
  sba_bus_type  sec_bus, pri_bus;
  sba_park_type sec_park, pri_park;
  int           fails, checked;

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  sba_arbiter uut (.mclk, .rst, .central_function_enable_n(strap), .sec_request_n,
    .sec_bus, .bridge_sec_request(want[0]), .prio_write, .prio_value, .pri_grant_n,
    .pri_request_n, .pri_bus, .pri_pending, .sec_grant_n, .bridge_sec_grant,
    .sec_start_ok, .pri_start_ok, .sec_park, .pri_park);

  sba_masters model (.mclk, .want, .stall, .slow, .ext_mode(strap), .ext_gnt,
    .sec_grant_n, .bridge_sec_grant, .sec_request_n, .sec_bus, .init, .start);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic check(input string name, input logic [15:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test;
    if (fails == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic do_reset(input logic s);
    rst = 1'b1;
    strap = s;
    want = 10'h000;
    stall = 10'h000;
    slow = 1'b0;
    ext_gnt = 1'b0;
    prio_write = 1'b0;
    prio_value = 10'h000;
    pri_grant_n = 1'b1;
    pri_request_n = 1'b1;
    pri_pending = 1'b0;
    pri_bus = '{1'b1, 1'b1};
    tick(16);
    rst = 1'b0;
    tick(1);
  endtask

  // A hung handshake counts as a mismatch and closes the run.
  task automatic wait_start(output logic [3:0] who);
    for (int n = 0; start !== 1'b1; n++) begin
      if (n > 300) begin
        check("start", 16'h0, 16'h1);
        finish_test;
      end
      tick(1);
    end
    who = init;
    tick(1);
  endtask

  task automatic chk_park(input logic pri);
    for (int n = 0; n < 10 && (pri ? pri_park.adcbe_oe : sec_park.adcbe_oe) !== 1'b1; n++)
      tick(1);
    check("park", pri ? pri_park.adcbe_oe : sec_park.adcbe_oe, 1);
    check("parity early", pri ? pri_park.par_oe : sec_park.par_oe, 0);
    tick(1);
    check("parity", pri ? pri_park.par_oe : sec_park.par_oe, 1);
  endtask

  // No grant may rise in the edge where another falls while the bus idles.
  always @(negedge mclk) begin
    if (!rst && !strap && ip && ipp)
      check("idle swap", |(pg & ~{~sec_grant_n, bridge_sec_grant}) &&
        |({~sec_grant_n, bridge_sec_grant} & ~pg), 0);
    pg <= {~sec_grant_n, bridge_sec_grant};
    ip <= sec_bus.cycle_frame_n & sec_bus.initiator_ready_n;
    ipp <= ip;
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_park;
    logic [3:0] who;
    do_reset(1'b0);
    check("reset grants", sec_grant_n, 9'h1ff);
    check("bridge parked", bridge_sec_grant, 1);
    chk_park(1'b0);
    want = 10'h008;
    wait_start(who);
    check("initiator", who, 3);
    want = 10'h000;
    tick(6);
    check("parked grant", sec_grant_n, 9'h1fb);
    check("bridge grant", bridge_sec_grant, 0);
  endtask

  task automatic t_rotate(input logic [9:0] prio, input int n, input logic [63:0] seq);
    logic [3:0] who;
    do_reset(1'b0);
    prio_value = prio;
    prio_write = 1'b1;
    tick(1);
    prio_write = 1'b0;
    slow = prio[9];
    want = 10'h3ff;
    for (int k = 0; k < n; k++) begin
      wait_start(who);
      check("initiator", who, seq[4*k +: 4]);
    end
    want = 10'h000;
  endtask

  task automatic t_preempt;
    do_reset(1'b0);
    prio_value = 10'h041;
    prio_write = 1'b1;
    tick(1);
    prio_write = 1'b0;
    stall = 10'h042;
    want = 10'h002;
    tick(4);
    check("low grant", sec_grant_n, 9'h1fe);
    want = 10'h042;
    tick(3);
    check("high grant", sec_grant_n, 9'h1df);
  endtask

  task automatic t_timeout;
    int n;
    logic [3:0] who;
    do_reset(1'b0);
    stall = 10'h020;
    want = 10'h020;
    for (n = 0; n < 20 && sec_grant_n[4] !== 1'b0; n++) tick(1);
    for (n = 0; n < 40 && sec_grant_n[4] === 1'b0; n++) tick(1);
    check("granted cycles", n, 16);
    tick(8);
    check("blocked", sec_grant_n[4], 1);
    want = 10'h000;
    tick(1);
    want = 10'h020;
    stall = 10'h000;
    wait_start(who);
    check("initiator", who, 5);
  endtask

  task automatic t_ext;
    do_reset(1'b1);
    check("unused grants", sec_grant_n[8:1], 8'hff);
    check("request out", sec_grant_n[0], 1);
    want = 10'h001;
    tick(2);
    check("request out", sec_grant_n[0], 0);
    ext_gnt = 1'b1;
    tick(1);
    check("start", sec_start_ok, 1);
    check("no park", sec_park.adcbe_oe, 0);
    want = 10'h000;
    chk_park(1'b0);
  endtask

  task automatic t_pri;
    do_reset(1'b0);
    pri_grant_n = 1'b0;
    pri_request_n = 1'b0;
    tick(4);
    check("primary park", pri_park.adcbe_oe, 0);
    pri_request_n = 1'b1;
    chk_park(1'b1);
    pri_pending = 1'b1;
    tick(2);
    check("primary start", pri_start_ok, 1);
    pri_grant_n = 1'b1;
    tick(1);
    check("release", pri_park.adcbe_oe, 0);
    check("release par", pri_park.par_oe, 0);
  endtask

  initial begin
    fails = 0;
    checked = 0;
    pg = 10'h001;
    ip = 1'b0;
    ipp = 1'b0;
    do_reset(1'b0);
    t_park;
    t_rotate(10'h001, 6, 64'h302010);
    t_rotate(10'h007, 8, 64'h42103210);
    t_rotate(10'h3ff, 11, 64'h09876543210);
    t_preempt;
    t_timeout;
    t_ext;
    t_pri;
    finish_test;
  end
endmodule

/* File: verif/sba_masters.sv */
// Model of the secondary-bus masters, the bridge core and an external arbiter.
// Assumes the bench changes want, stall, slow and ext_gnt on falling edges.
`timescale 1ns/10ps

module sba_masters
  import sba_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic [9:0] want,
  input  wire logic [9:0] stall,
  input  wire logic       slow,
  input  wire logic       ext_mode,
  input  wire logic       ext_gnt,
  input  wire logic [8:0] sec_grant_n,
  input  wire logic       bridge_sec_grant,
  output logic      [8:0] sec_request_n,
  output sba_bus_type     sec_bus,
  output logic      [3:0] init,
  output logic            start
);
  logic [9:0] gnt;
  logic [9:0] go;
  logic [1:0] len;
  logic [1:0] lag;
  logic [3:0] who;

  // ****************************************************************
  // Masters
  // ****************************************************************
  assign gnt = {~sec_grant_n, bridge_sec_grant};
  assign go = gnt & want & ~stall;
  // Pull-ups hold the unused requests high; bit 0 carries the outside grant.
  assign sec_request_n = ext_mode ? {8'hff, ~ext_gnt} : ~want[9:1];

  always_comb begin
    who = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (go[i]) begin
        who = i[3:0];
      end
    end
  end

  initial begin
    len = 2'h0;
    lag = 2'h0;
    init = 4'h0;
    start = 1'b0;
    sec_bus = '{1'b1, 1'b1};
  end

  // A stalled master holds its grant without ever starting, to force a timeout.
  always @(posedge mclk) begin
    start <= 1'b0;
    sec_bus <= '{1'b1, 1'b1};
    if (len == 2'h2) begin
      sec_bus <= '{1'b1, 1'b0};
    end
    if (len != 2'h0) begin
      len <= len - 2'h1;
    end else if (!ext_mode && |go) begin
      if (slow && lag != 2'h3) begin
        lag <= lag + 2'h1;
      end else begin
        lag <= 2'h0;
        len <= 2'h2;
        start <= 1'b1;
        init <= who;
        sec_bus <= '{1'b0, 1'b1};
      end
    end
  end
endmodule
